/* hdl/cosg_consts.vh */
`ifndef COSG_CONSTS_VH
`define COSG_CONSTS_VH

// register map, byte addresses on apb
`define COSG_ADDR_CTRL      12'h000
`define COSG_ADDR_STATUS    12'h004
`define COSG_ADDR_W         12

// control register fields
`define COSG_CTRL_OVR_EN    0
`define COSG_CTRL_SEL_LSB   1
`define COSG_CTRL_SEL_MSB   4
`define COSG_CTRL_RESET     32'h0000_0000

// status register fields
`define COSG_ST_STRAP_LSB   0
`define COSG_ST_STRAP_MSB   3
`define COSG_ST_MODE        4
`define COSG_ST_DONE        5
`define COSG_ST_DIV_LSB     6
`define COSG_ST_DIV_MSB     8
`define COSG_ST_SEL_LSB     9
`define COSG_ST_SEL_MSB     12
`define COSG_ST_PROC_RUN    13
`define COSG_ST_BUS_RUN     14

// bus clock divide ratios
`define COSG_DIV_BY2        3'h2
`define COSG_DIV_BY3        3'h3
`define COSG_DIV_BY4        3'h4

// timing
`define COSG_CLK_MHZ        50
`define COSG_STRAP_TIME_NS  1000
`define COSG_STRAP_CYCLES   ((`COSG_STRAP_TIME_NS * `COSG_CLK_MHZ + 999) / 1000)

`endif

/* hdl/cosg_sync.v */
`timescale 1ns/1ps
`default_nettype none

module cosg_sync
#(
  parameter RESET_VAL = 1'b1
)
(
  input  wire clk_sys,
  input  wire resetn,
  input  wire d_in,
  output wire q_out
);

  reg meta_q;
  reg sync_q;

  // first stage feeds only the second stage
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule // cosg_sync

`default_nettype wire

/* hdl/cosg_clk_gate.v */
`timescale 1ns/1ps
`default_nettype none

module cosg_clk_gate
(
  input  wire clk_sys,
  input  wire resetn,
  input  wire src_d,
  input  wire src_q,
  input  wire run,
  output wire gated_clk,
  output wire running
);

  reg  en_q;
  reg  out_q;
  wire en_d;

  // decide only at a rising edge of the source: whole pulses or none, no runts
  assign en_d = (!src_q && src_d) ? run : en_q; // RULE_19

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      en_q  <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      en_q  <= en_d; // RULE_10 RULE_11
      out_q <= src_d & en_d;
    end
  end

  assign gated_clk = out_q;
  assign running   = en_q;

endmodule // cosg_clk_gate

`default_nettype wire

/* hdl/cosg_top.v */
// How it works
// RULE_01: divide ratio from select code: 11xx by four, 10xx/01xx/0000 three, else two.
// RULE_02: mode 0 makes shared pin a stop input; mode 1 drives reference output there.
// RULE_03: software may override the strapped select code through the register interface.
// RULE_04: gated processor outputs halt while clock-stop input is low.
// RULE_05: free processor output always toggles, ignoring clock-stop.
// RULE_06: gated bus outputs halt while the bus stop input is asserted.
// RULE_07: free bus output always toggles, ignoring bus stop.
// RULE_08: bus output zero pin is sampled at power-up as select bit three.
// RULE_09: free bus output pin is sampled at power-up as the mode strap.
// RULE_10: on clock-stop fall, finish current cycle then hold low, within 2-3 cycles.
// RULE_11: on clock-stop rise, restart with a full cycle, no runts, within 2-3 cycles.
// RULE_12: free interrupt-controller clock is a copy of the reference input.
// RULE_13: gated interrupt-controller clock copies the reference, off while clock-stop low.
// RULE_14: usb pin sampled as select bit one, then drives the fixed usb clock.
// RULE_15: bus stop sampled at free bus clock rise, effective next bus cycle.
// RULE_16: all strap pins latched shortly after power-up, then become clock outputs.
// RULE_17: 24 MHz pin gives select bit zero, reference one pin gives bit two.
// RULE_18: strap window counted from reset release; pin drivers enabled after latching.
// RULE_19: stop inputs synchronised; gating changes only while the clock is low.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cosg_consts.vh"

module cosg_top
#(
  parameter STRAP_CYCLES = `COSG_STRAP_CYCLES,
  parameter PROC_GATED_N = 2,
  parameter BUS_GATED_N  = 5
)
(
  input  wire                    clk_sys,
  input  wire                    resetn,
  // apb slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [31:0]             paddr,
  input  wire [31:0]             pwdata,
  output wire [31:0]             prdata,
  output wire                    pready,
  output wire                    pslverr,
  // clock sources, sampled as ordinary inputs
  input  wire                    ref_clk_in,
  input  wire                    usb_clk_src,
  input  wire                    sio_clk_src,
  input  wire                    clk_stop_n,
  // select code toward the frequency synthesiser
  output wire [3:0]              pll_freq_sel,
  // processor clocks
  output wire                    proc_clk_free,
  output wire [PROC_GATED_N-1:0] proc_clk_gated,
  // bus and interrupt-controller clocks
  output wire [BUS_GATED_N-1:0]  bus_clk_gated,
  output wire                    irq_ctrl_clk_free,
  output wire                    irq_ctrl_clk_gated,
  // dual-purpose pins: bus output zero / select bit three
  input  wire                    bus_clk_zero_i,
  output wire                    bus_clk_zero_o,
  output wire                    bus_clk_zero_oe,
  // free bus output / mode strap
  input  wire                    bus_clk_free_i,
  output wire                    bus_clk_free_o,
  output wire                    bus_clk_free_oe,
  // usb clock / select bit one
  input  wire                    usb_ref_clk_i,
  output wire                    usb_ref_clk_o,
  output wire                    usb_ref_clk_oe,
  // 24 MHz clock / select bit zero
  input  wire                    sio_clk_i,
  output wire                    sio_clk_o,
  output wire                    sio_clk_oe,
  // reference output one / select bit two
  input  wire                    ref_clk_out1_i,
  output wire                    ref_clk_out1_o,
  output wire                    ref_clk_out1_oe,
  // reference output zero / bus stop input
  input  wire                    ref_clk_out0_i,
  output wire                    ref_clk_out0_o,
  output wire                    ref_clk_out0_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // strap capture

  reg  [15:0] strap_cnt_q;
  reg         strap_done_q;
  reg  [3:0]  freq_sel_q;
  reg         mode_q;

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_cnt_q  <= 16'h0000;
      strap_done_q <= 1'b0;
      freq_sel_q   <= 4'h0;
      mode_q       <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      // pins are inputs only while the window is open
      if (strap_cnt_q == STRAP_CYCLES[15:0] - 16'h0001) // RULE_18
      begin
        strap_done_q <= 1'b1; // RULE_16
        freq_sel_q   <= {bus_clk_zero_i, ref_clk_out1_i, usb_ref_clk_i, sio_clk_i}; // RULE_08 RULE_14 RULE_17
        mode_q       <= bus_clk_free_i; // RULE_09
      end
      else
      begin
        strap_cnt_q <= strap_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register interface

  reg  [31:0] ctrl_q;
  reg  [31:0] prdata_q;
  wire [11:0] addr_w;
  wire        hit_ctrl;
  wire        hit_status;
  wire [31:0] status_w;
  wire        proc_running;
  wire        bus_running;
  reg  [2:0]  div_q;
  wire [3:0]  freq_sel_eff;

  assign addr_w     = paddr[`COSG_ADDR_W-1:0];
  assign hit_ctrl   = (paddr[31:`COSG_ADDR_W] == 20'h00000) && (addr_w == `COSG_ADDR_CTRL);
  assign hit_status = (paddr[31:`COSG_ADDR_W] == 20'h00000) && (addr_w == `COSG_ADDR_STATUS);

  assign status_w = {17'h00000, bus_running, proc_running, freq_sel_eff, div_q,
                     strap_done_q, mode_q, freq_sel_q};

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q   <= `COSG_CTRL_RESET;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      // read data is fetched in the setup phase so the access needs no wait
      if (psel && !penable && !pwrite)
      begin
        if (hit_ctrl)
          prdata_q <= ctrl_q;
        else if (hit_status)
          prdata_q <= status_w;
        else
          prdata_q <= 32'h0000_0000;
      end
      if (psel && penable && pwrite && hit_ctrl)
        ctrl_q <= {27'h0000000, pwdata[`COSG_CTRL_SEL_MSB:`COSG_CTRL_OVR_EN]};
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(hit_ctrl || (hit_status && !pwrite));

  // override replaces the strapped code for both synthesiser and divider
  assign freq_sel_eff = ctrl_q[`COSG_CTRL_OVR_EN] ?
                        ctrl_q[`COSG_CTRL_SEL_MSB:`COSG_CTRL_SEL_LSB] : freq_sel_q; // RULE_03
  assign pll_freq_sel = freq_sel_eff;

  ////////////////////////////////////////////////////////////////////////////
  // clock generation

  reg  [2:0] div_sel;
  reg  [2:0] cnt_q;
  wire [2:0] cnt_d;
  wire [2:0] div_d;
  wire       wrap;
  wire       proc_d;
  wire       bus_d;
  reg        proc_q;
  reg        bus_q;
  reg        ref_q;
  reg        usb_q;
  reg        sio_q;

  always @*
  begin
    div_sel = `COSG_DIV_BY2;
    case (freq_sel_eff[3:2])
      2'b11:   div_sel = `COSG_DIV_BY4; // RULE_01
      2'b10:   div_sel = `COSG_DIV_BY3;
      2'b01:   div_sel = `COSG_DIV_BY3;
      default: div_sel = (freq_sel_eff[1:0] == 2'b00) ? `COSG_DIV_BY3 : `COSG_DIV_BY2;
    endcase
  end

  // ratio changes only at a bus period boundary to avoid a short bus pulse
  assign wrap   = (cnt_q == {div_q[1:0], 1'b0} - 3'h1);
  assign cnt_d  = (!strap_done_q || wrap) ? 3'h0 : cnt_q + 3'h1;
  assign div_d  = wrap ? div_sel : div_q;
  assign proc_d = strap_done_q && !cnt_d[0];
  assign bus_d  = strap_done_q && (cnt_d < div_d);

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q  <= 3'h0;
      div_q  <= `COSG_DIV_BY3;
      proc_q <= 1'b0;
      bus_q  <= 1'b0;
      ref_q  <= 1'b0;
      usb_q  <= 1'b0;
      sio_q  <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      div_q  <= strap_done_q ? div_d : div_sel;
      proc_q <= proc_d; // RULE_05
      bus_q  <= bus_d; // RULE_07
      ref_q  <= ref_clk_in; // RULE_12
      usb_q  <= usb_clk_src & strap_done_q;
      sio_q  <= sio_clk_src & strap_done_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop inputs

  wire clk_run_s;
  wire bus_stop_raw_s;
  wire bus_run_now;
  reg  bus_run_q;

  cosg_sync #(.RESET_VAL(1'b1)) u_clk_stop_sync
  (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d_in    (clk_stop_n),
    .q_out   (clk_run_s)
  ); // RULE_19

  cosg_sync #(.RESET_VAL(1'b1)) u_bus_stop_sync
  (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d_in    (ref_clk_out0_i),
    .q_out   (bus_stop_raw_s)
  );

  // in mode 1 the pin is an output, so stop can never be asserted
  assign bus_run_now = mode_q | bus_stop_raw_s; // RULE_02

  // sampled at free bus clock rise; the gates read the old value, so next cycle
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      bus_run_q <= 1'b1;
    else if (bus_d && !bus_q)
      bus_run_q <= bus_run_now; // RULE_15
  end

  ////////////////////////////////////////////////////////////////////////////
  // gated outputs

  wire [PROC_GATED_N-1:0] proc_run_w;
  wire [BUS_GATED_N:0]    bus_run_w;
  wire [BUS_GATED_N:0]    bus_gated_w;
  wire                    ref_d;

  genvar gi;
  generate
    for (gi = 0; gi < PROC_GATED_N; gi = gi + 1)
    begin : g_proc
      cosg_clk_gate u_gate
      (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .src_d     (proc_d),
        .src_q     (proc_q),
        .run       (clk_run_s),
        .gated_clk (proc_clk_gated[gi]),
        .running   (proc_run_w[gi])
      ); // RULE_04
    end
    // entry 0 is the dual-purpose bus output zero
    for (gi = 0; gi <= BUS_GATED_N; gi = gi + 1)
    begin : g_bus
      cosg_clk_gate u_gate
      (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .src_d     (bus_d),
        .src_q     (bus_q),
        .run       (bus_run_q),
        .gated_clk (bus_gated_w[gi]),
        .running   (bus_run_w[gi])
      ); // RULE_06
    end
  endgenerate

  assign ref_d = ref_clk_in;

  cosg_clk_gate u_irq_gate
  (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .src_d     (ref_d),
    .src_q     (ref_q),
    .run       (clk_run_s),
    .gated_clk (irq_ctrl_clk_gated),
    .running   ()
  ); // RULE_13

  assign proc_running = proc_run_w[0];
  assign bus_running  = bus_run_w[0];

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  assign proc_clk_free     = proc_q;
  assign bus_clk_gated     = bus_gated_w[BUS_GATED_N:1];
  assign irq_ctrl_clk_free = ref_q; // RULE_12

  assign bus_clk_zero_o   = bus_gated_w[0];
  assign bus_clk_zero_oe  = strap_done_q; // RULE_18
  assign bus_clk_free_o   = bus_q;
  assign bus_clk_free_oe  = strap_done_q;
  assign usb_ref_clk_o    = usb_q; // RULE_14
  assign usb_ref_clk_oe   = strap_done_q;
  assign sio_clk_o        = sio_q;
  assign sio_clk_oe       = strap_done_q;
  assign ref_clk_out1_o   = ref_q & strap_done_q;
  assign ref_clk_out1_oe  = strap_done_q;
  assign ref_clk_out0_o   = ref_q & mode_q; // RULE_02
  assign ref_clk_out0_oe  = strap_done_q & mode_q;

endmodule // cosg_top

`default_nettype wire

/* sim/cosg_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cosg_top_sva
#(
  parameter STRAP_CYCLES = 50
)
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       ref_clk_in,
  input wire logic       usb_clk_src,
  input wire logic       sio_clk_src,
  input wire logic       clk_stop_n,
  input wire logic       proc_clk_free,
  input wire logic [1:0] proc_clk_gated,
  input wire logic       irq_ctrl_clk_free,
  input wire logic       irq_ctrl_clk_gated,
  input wire logic       bus_clk_free_i,
  input wire logic       bus_clk_free_oe,
  input wire logic       usb_ref_clk_o,
  input wire logic       usb_ref_clk_oe,
  input wire logic       sio_clk_o,
  input wire logic       sio_clk_oe,
  input wire logic       ref_clk_out1_oe,
  input wire logic       bus_clk_zero_oe,
  input wire logic       ref_clk_out0_oe
);
  // saturates so a long run never wraps back into the strap window
  logic [7:0] cnt_q;
  logic       mode_q;
  always @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      cnt_q  <= 8'h00;
      mode_q <= 1'b0;
    end
    else
    begin
      if (cnt_q != 8'hff)
        cnt_q <= cnt_q + 8'h01;
      if (!bus_clk_free_oe)
        mode_q <= bus_clk_free_i;
    end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  strap_late_a: assert property (cnt_q > STRAP_CYCLES |-> bus_clk_free_oe)
    else $error("strap window too long");
  strap_early_a: assert property (cnt_q + 1 < STRAP_CYCLES |-> !bus_clk_free_oe)
    else $error("pins driven before strap latch");
  pin_oe_sync_a: assert property (bus_clk_free_oe == bus_clk_free_oe
    && {usb_ref_clk_oe, sio_clk_oe, ref_clk_out1_oe, bus_clk_zero_oe} == {4{bus_clk_free_oe}})
    else $error("strap pin enables differ");
  ref_pin_mode_a: assert property (ref_clk_out0_oe == (bus_clk_free_oe && mode_q))
    else $error("shared pin function wrong");
  irq_free_copy_a: assert property ($past(resetn) |-> irq_ctrl_clk_free == $past(ref_clk_in))
    else $error("free irq clock not a copy");
  usb_copy_a: assert property (usb_ref_clk_oe && $past(usb_ref_clk_oe)
    |-> usb_ref_clk_o == $past(usb_clk_src))
    else $error("usb clock not a copy");
  sio_copy_a: assert property (sio_clk_oe && $past(sio_clk_oe)
    |-> sio_clk_o == $past(sio_clk_src))
    else $error("24 MHz clock not a copy");
  // first free pulse comes two cycles after the pins turn on
  proc_free_run_a: assert property (bus_clk_free_oe && $past(bus_clk_free_oe, 2)
    |-> proc_clk_free != $past(proc_clk_free))
    else $error("free proc clock stalled");
  proc_stop_a: assert property ((!clk_stop_n)[*7] |-> proc_clk_gated == 2'h0)
    else $error("gated proc clock not stopped");
  irq_stop_a: assert property ((!clk_stop_n)[*7] |-> !irq_ctrl_clk_gated)
    else $error("gated irq clock not stopped");
  proc_restart_a: assert property ((clk_stop_n && bus_clk_free_oe)[*7]
    |-> proc_clk_gated != $past(proc_clk_gated))
    else $error("gated proc clock not running");
  whole_pulse_a: assert property (proc_clk_gated[0] |-> proc_clk_free)
    else $error("runt on gated proc clock");
endmodule // cosg_top_sva
bind cosg_top cosg_top_sva #(.STRAP_CYCLES(STRAP_CYCLES)) u_sva
(
  .clk_sys            (clk_sys),
  .resetn             (resetn),
  .ref_clk_in         (ref_clk_in),
  .usb_clk_src        (usb_clk_src),
  .sio_clk_src        (sio_clk_src),
  .clk_stop_n         (clk_stop_n),
  .proc_clk_free      (proc_clk_free),
  .proc_clk_gated     (proc_clk_gated),
  .irq_ctrl_clk_free  (irq_ctrl_clk_free),
  .irq_ctrl_clk_gated (irq_ctrl_clk_gated),
  .bus_clk_free_i     (bus_clk_free_i),
  .bus_clk_free_oe    (bus_clk_free_oe),
  .usb_ref_clk_o      (usb_ref_clk_o),
  .usb_ref_clk_oe     (usb_ref_clk_oe),
  .sio_clk_o          (sio_clk_o),
  .sio_clk_oe         (sio_clk_oe),
  .ref_clk_out1_oe    (ref_clk_out1_oe),
  .bus_clk_zero_oe    (bus_clk_zero_oe),
  .ref_clk_out0_oe    (ref_clk_out0_oe)
);
`default_nettype wire

/* sim/cosg_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module cosg_pins
(
  input  wire logic [4:0] strap_val,
  input  wire logic       stop_lvl,
  input  wire logic       bus_clk_zero_o,
  input  wire logic       bus_clk_zero_oe,
  input  wire logic       bus_clk_free_o,
  input  wire logic       bus_clk_free_oe,
  input  wire logic       usb_ref_clk_o,
  input  wire logic       usb_ref_clk_oe,
  input  wire logic       sio_clk_o,
  input  wire logic       sio_clk_oe,
  input  wire logic       ref_clk_out1_o,
  input  wire logic       ref_clk_out1_oe,
  input  wire logic       ref_clk_out0_o,
  input  wire logic       ref_clk_out0_oe,
  output logic            bus_clk_zero_i,
  output logic            bus_clk_free_i,
  output logic            usb_ref_clk_i,
  output logic            sio_clk_i,
  output logic            ref_clk_out1_i,
  output logic            ref_clk_out0_i
);
  // strap resistors win whenever the device releases a pin
  assign bus_clk_zero_i = bus_clk_zero_oe ? bus_clk_zero_o : strap_val[3];
  assign usb_ref_clk_i  = usb_ref_clk_oe ? usb_ref_clk_o : strap_val[1];
  assign sio_clk_i      = sio_clk_oe ? sio_clk_o : strap_val[0];
  assign ref_clk_out1_i = ref_clk_out1_oe ? ref_clk_out1_o : strap_val[2];
  assign bus_clk_free_i = bus_clk_free_oe ? bus_clk_free_o : strap_val[4];
  // chipset drives the stop level only while the pin is an input
  assign ref_clk_out0_i = ref_clk_out0_oe ? ref_clk_out0_o : stop_lvl;
endmodule // cosg_pins
`default_nettype wire

/* sim/tb_clock_output_select_gating.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cosg_consts.vh"
module tb_clock_output_select_gating;
  logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ref_clk_in = 0, usb_clk_src = 0, sio_clk_src = 0, clk_stop_n = 1, stop_lvl = 1;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [4:0] strap_val = 0, bus_clk_gated;
  logic [3:0] pll_freq_sel;
  logic [1:0] proc_clk_gated;
  logic pready, pslverr, proc_clk_free, irq_ctrl_clk_free, irq_ctrl_clk_gated, err, ref_d;
  logic bus_clk_zero_i, bus_clk_zero_o, bus_clk_zero_oe, bus_clk_free_i, bus_clk_free_o;
  logic bus_clk_free_oe, usb_ref_clk_i, usb_ref_clk_o, usb_ref_clk_oe, sio_clk_i, sio_clk_o;
  logic sio_clk_oe, ref_clk_out1_i, ref_clk_out1_o, ref_clk_out1_oe;
  logic ref_clk_out0_i, ref_clk_out0_o, ref_clk_out0_oe;
  logic [31:0] rng = 32'h0001_67a7;
  int mismatches = 0, checks = 0, cyc = 0, h, tg_pf, tg_bf, hi_pg, hi_bg, hi_ig, bad_rf;
  cosg_top #(.STRAP_CYCLES(8)) u_dut (.*);
  cosg_pins u_pins (.*);
  //////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [2:0] div_of(input logic [3:0] s);
    if (s[3:2] == 2'h3)
      return 3'h4;
    if (s[3:2] != 2'h0 || s == 4'h0)
      return 3'h3;
    return 3'h2;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic watch(input int n);
    logic pf, bf;
    {tg_pf, tg_bf, hi_pg, hi_bg, hi_ig, bad_rf} = '0;
    repeat (n)
    begin
      pf = proc_clk_free;
      bf = bus_clk_free_o;
      @(negedge clk_sys);
      tg_pf += (pf !== proc_clk_free);
      tg_bf += (bf !== bus_clk_free_o);
      hi_pg += (proc_clk_gated === 2'h3);
      hi_bg += ({bus_clk_gated, bus_clk_zero_o} !== 6'h00);
      hi_ig += (irq_ctrl_clk_gated !== 1'b0);
      bad_rf += (ref_clk_out0_o !== ref_d) || (ref_clk_out1_o !== ref_d);
    end
  endtask
  // sampled at the falling edge so a half period counts whole cycles
  task automatic half_n;
    @(negedge clk_sys);
    while (bus_clk_free_o !== 1'b0)
      @(negedge clk_sys);
    while (bus_clk_free_o !== 1'b1)
      @(negedge clk_sys);
    h = 0;
    while (bus_clk_free_o === 1'b1)
    begin
      h++;
      @(negedge clk_sys);
    end
  endtask
  task automatic step(input logic cs, input logic ps);
    @(posedge clk_sys);
    clk_stop_n <= cs;
    stop_lvl <= ps;
    repeat (40) @(posedge clk_sys);
    watch(24);
  endtask
  //////////////////////////////
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    rng <= xs(rng);
    // steady reference so every stop window sees its rising edges
    ref_clk_in <= cyc[1];
    {usb_clk_src, sio_clk_src} <= rng[1:0];
    ref_d <= ref_clk_in;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      mismatches++;
      complete_run();
    end
  end
  initial
  begin
    for (int r = 0; r < 3; r++)
    begin
      @(posedge clk_sys);
      strap_val <= {r[0], rng[7:4]};
      resetn <= 1'b0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      while (bus_clk_free_oe !== 1'b1)
        @(posedge clk_sys);
      // ratio switches only at a bus wrap, so status is read after a new period
      half_n();
      half_n();
      chk("half period", div_of(strap_val[3:0]), h);
      apb(1'b0, `COSG_ADDR_STATUS, 0);
      chk("status", {div_of(strap_val[3:0]), 1'b1, strap_val}, rd[8:0]);
      chk("pll sel", strap_val[3:0], pll_freq_sel);
      if (r == 1)
      begin
        step(1'b1, 1'b0);
        chk("ref copies", 0, bad_rf);
        chk("bus gated mode1", 12, hi_bg);
      end
      if (r == 0)
      begin
        apb(1'b0, `COSG_ADDR_CTRL, 0);
        chk("ctrl reset", `COSG_CTRL_RESET, rd);
        for (int c = 0; c < 16; c++)
        begin
          apb(1'b1, `COSG_ADDR_CTRL, {c[3:0], 1'b1});
          half_n();
          half_n();
          chk("ovr half", div_of(c[3:0]), h);
          apb(1'b0, `COSG_ADDR_STATUS, 0);
          chk("eff sel", {c[3:0], div_of(c[3:0])}, rd[12:6]);
          chk("pll ovr", c[3:0], pll_freq_sel);
        end
        apb(1'b1, `COSG_ADDR_CTRL, 0);
        apb(1'b0, 32'h0000_1000, 0);
        chk("unmapped", 32'h1, {rd, err});
        apb(1'b1, `COSG_ADDR_STATUS, 32'hffff_ffff);
        chk("ro write", 1, err);
        step(1'b0, 1'b1);
        chk("proc stopped", 0, hi_pg);
        chk("irq stopped", 0, hi_ig);
        chk("proc free", 24, tg_pf);
        apb(1'b0, `COSG_ADDR_STATUS, 0);
        chk("proc run bit", 0, rd[13]);
        step(1'b1, 1'b1);
        chk("proc restart", 12, hi_pg);
        step(1'b1, 1'b0);
        chk("bus stopped", 0, hi_bg);
        chk("bus free", 1, tg_bf > 0);
        apb(1'b0, `COSG_ADDR_STATUS, 0);
        chk("bus run bit", 0, rd[14]);
        step(1'b1, 1'b1);
        chk("bus restart", 12, hi_bg);
      end
    end
    complete_run();
  end
endmodule // tb_clock_output_select_gating
`default_nettype wire
